/* audio_port_regs.svh */
`ifndef AUDIO_PORT_REGS_SVH
`define AUDIO_PORT_REGS_SVH

// register indices; the byte address is four times the index
`define IDX_RX_FIFO_PORT 24'hfffd40
`define IDX_RX_DMA_SLOT0 24'hfffd42
`define IDX_RX_DMA_SLOT1 24'hfffd44
`define IDX_RX_DMA_SLOT2 24'hfffd46
`define IDX_RX_DMA_SLOT3 24'hfffd48
`define IDX_TX_FIFO_PORT 24'hfffd4a
`define IDX_TX_DMA_SLOT0 24'hfffd4c
`define IDX_TX_DMA_SLOT1 24'hfffd4e
`define IDX_TX_DMA_SLOT2 24'hfffd50
`define IDX_TX_DMA_SLOT3 24'hfffd52
`define IDX_GLOBAL_CONFIG 24'hfffd54
`define IDX_IRQ_STATUS_CTRL 24'hfffd56
`define IDX_RX_STATUS_CTRL 24'hfffd58
`define IDX_TX_STATUS_CTRL 24'hfffd5a
`define IDX_CLOCK_CTRL 24'hfffd5c
`define IDX_DMA_CTRL 24'hfffd5e

// reset values
`define CFG_RESET 16'h0000
`define CLKC_RESET 16'h1f03
`define ZERO16 16'h0000

// status/control field positions (rx and tx status registers)
`define STAT_STICKY 8
`define STAT_FULL 9
`define STAT_EMPTY 10
`define STAT_LEVEL 11
`define TXC_CVAL_LSB 0
`define TXC_CVAL_MSB 2
`define TXC_CCNT_LSB 3
`define TXC_CCNT_MSB 4

// dma control bits
`define DMAC_RX 0
`define DMAC_TX 1

// clock control fields
`define CLKC_DIV_LSB 0
`define CLKC_DIV_MSB 7
`define CLKC_FRAME_LSB 8
`define CLKC_FRAME_MSB 15

// word and sync lengths in bit clocks
`define WORD_NARROW 5'd8
`define WORD_WIDE 5'd16
`define SYNC_SHORT 5'd1
`define SYNC_LONG_NARROW 5'd6
`define SYNC_LONG_WIDE_BASE 5'd13

`endif

/* audio_port_pkg.sv */
package audio_port_pkg;

	// global configuration layout, msb first
	typedef struct packed {
		logic clk_en;
		logic port_en;
		logic isdn_slave_mode_bit;
		logic sync_invert_bit;
		logic [1:0] sync_length_field;
		logic clr_tx;
		logic clr_rx;
		logic ext_bitclk_select;
		logic sync_length_select;
		logic ext_sync_select;
		logic [1:0] slot_count_select;
		logic loopback_bit;
		logic word_length_select;
		logic async_select;
	} cfg_s;

	// synchronised link inputs
	typedef struct packed {
		logic sck;
		logic sfs;
		logic rxd;
	} pins_s;

	typedef enum logic [1:0] {LINK_IDLE, LINK_DATA, LINK_CTRL} link_state_e;

endpackage

/* audio_port.sv */
`timescale 1ns/1ps
`include "audio_port_regs.svh"

module audio_port
	import audio_port_pkg::*;
#(
	parameter int FIFO_DEPTH = 16,
	parameter int RX_AF_LEVEL = 12,
	parameter int TX_AE_LEVEL = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe_n,
	input wire logic sfs_in,
	output logic sfs_out,
	output logic sfs_oe_n,
	input wire logic serial_rx_pin,
	output logic serial_tx_pin,
	output logic serial_tx_oe_n,
	input wire logic freeze
);

	localparam int PTR_W = $clog2(FIFO_DEPTH);
	localparam logic [PTR_W:0] DEPTH_C = (PTR_W+1)'(FIFO_DEPTH);
	localparam logic [PTR_W:0] RX_AF_C = (PTR_W+1)'(RX_AF_LEVEL);
	localparam logic [PTR_W:0] TX_AE_C = (PTR_W+1)'(TX_AE_LEVEL);

	// input synchronisers
	logic [2:0] pin_meta_ff, pin_sync_ff;
	logic frz_meta_ff, frz_ff;
	pins_s pin;

	// registers
	logic [15:0] gcfg_ff, nxt_gcfg;
	logic [15:0] irqc_ff, nxt_irqc;
	logic [15:0] clkc_ff, nxt_clkc;
	logic [15:0] dmac_ff, nxt_dmac;
	logic [4:0] txc_ff, nxt_txc;
	logic [15:0] rx_dma0_ff, nxt_rx_dma0;
	logic [15:0] tx_dma0_ff, nxt_tx_dma0;
	logic rx_ovr_ff, nxt_rx_ovr;
	logic tx_und_ff, nxt_tx_und;
	logic [15:0] rx_mem_ff [FIFO_DEPTH];
	logic [15:0] nxt_rx_mem [FIFO_DEPTH];
	logic [15:0] tx_mem_ff [FIFO_DEPTH];
	logic [15:0] nxt_tx_mem [FIFO_DEPTH];
	logic [PTR_W-1:0] rx_wptr_ff, nxt_rx_wptr, rx_read_ptr_ff, nxt_rx_read_ptr;
	logic [PTR_W-1:0] tx_wptr_ff, nxt_tx_wptr, tx_rptr_ff, nxt_tx_rptr;
	logic rx_lastw_ff, nxt_rx_lastw, tx_lastw_ff, nxt_tx_lastw;
	logic [15:0] tx_last_ff, nxt_tx_last;
	logic pready_ff, nxt_pready;
	logic pslverr_ff, nxt_pslverr;
	logic [31:0] prdata_ff, nxt_prdata;

	// clock and sync generation
	logic [7:0] div_cnt_ff, nxt_div_cnt;
	logic int_sck_ff, nxt_int_sck;
	logic sck_prev_ff, nxt_sck_prev;
	logic [7:0] gen_cnt_ff, nxt_gen_cnt;
	logic sfs_out_ff, nxt_sfs_out;
	logic [1:0] smp_ff, nxt_smp;

	// link
	link_state_e state_ff, nxt_state;
	logic [4:0] bit_cnt_ff, nxt_bit_cnt;
	logic [1:0] ctl_cnt_ff, nxt_ctl_cnt;
	logic phase_ff, nxt_phase;
	logic [15:0] tx_shift_reg_ff, nxt_tx_shift_reg;
	logic [15:0] rx_shift_reg_ff, nxt_rx_shift_reg;
	logic tx_bit_ff, nxt_tx_bit;

	cfg_s cfg;
	logic iom, ext_clk, ext_sync, long_sync, wide;
	logic [4:0] word_bits, sync_len;
	logic [1:0] ctrl_bit_count;
	logic [2:0] ctrl_bits_value;
	logic tick, bclk_rise, bclk_fall, shift_rise, shift_fall, sync_lvl, start;
	logic rx_in, rx_done, tx_load;
	logic [15:0] rx_word, tx_word;
	logic rx_full, rx_empty, tx_full, tx_empty;
	logic [PTR_W:0] rx_cnt, tx_cnt;
	logic [PTR_W-1:0] rx_diff, tx_diff;
	logic [23:0] idx;
	logic addr_ok, done, wr, rd;

	// two-stage synchronisers for pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_ff <= 3'h0;
			pin_sync_ff <= 3'h0;
		end else begin
			pin_meta_ff <= {sck_in, sfs_in, serial_rx_pin};
			pin_sync_ff <= pin_meta_ff;
		end
	end
	assign pin = pins_s'(pin_sync_ff);

	// freeze synchroniser, latency of two pclk cycles
	// two-stage freeze
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frz_meta_ff <= 1'b0;
			frz_ff <= 1'b0;
		end else begin
			frz_meta_ff <= freeze;
			frz_ff <= frz_meta_ff;
		end
	end

	// effective configuration
	assign cfg = cfg_s'(gcfg_ff);
	assign iom = cfg.isdn_slave_mode_bit;
	assign ext_clk = cfg.ext_bitclk_select | iom;
	assign ext_sync = cfg.ext_sync_select | iom;
	assign long_sync = cfg.sync_length_select | iom;
	assign wide = cfg.word_length_select | iom;
	assign word_bits = wide ? `WORD_WIDE : `WORD_NARROW;
	assign sync_len = !long_sync ? `SYNC_SHORT :
		(wide ? `SYNC_LONG_WIDE_BASE + {3'b000, cfg.sync_length_field} : `SYNC_LONG_NARROW);
	assign ctrl_bit_count = txc_ff[`TXC_CCNT_MSB:`TXC_CCNT_LSB];
	assign ctrl_bits_value = txc_ff[`TXC_CVAL_MSB:`TXC_CVAL_LSB];

	// bit clock edges, internal divider or sampled pin
	assign tick = cfg.clk_en && (div_cnt_ff == clkc_ff[`CLKC_DIV_MSB:`CLKC_DIV_LSB]);
	assign bclk_rise = ext_clk ? (pin.sck & ~sck_prev_ff) : (tick & ~int_sck_ff);
	assign bclk_fall = ext_clk ? (~pin.sck & sck_prev_ff) : (tick & int_sck_ff);
	assign shift_rise = bclk_rise & (~iom | ~phase_ff);
	assign shift_fall = bclk_fall & (~iom | ~phase_ff);
	assign sync_lvl = ext_sync ? (pin.sfs ^ cfg.sync_invert_bit) : (sfs_out_ff ^ cfg.sync_invert_bit);

	// frame start detection from last two falling-edge samples
	// after sync rises for long sync, after sync falls for short sync
	assign start = bclk_rise & cfg.port_en & (long_sync ? (smp_ff[0] & ~smp_ff[1]) : (smp_ff[1] & ~smp_ff[0]));

	// divider, edge history and sync generator
	always_comb begin
		nxt_div_cnt = tick ? 8'h00 : (cfg.clk_en ? div_cnt_ff + 8'h01 : 8'h00);
		nxt_int_sck = tick ? ~int_sck_ff : int_sck_ff;
		nxt_sck_prev = pin.sck;
		nxt_gen_cnt = gen_cnt_ff;
		nxt_sfs_out = sfs_out_ff;
		nxt_smp = smp_ff;
		if (bclk_fall) begin
			nxt_smp = {smp_ff[0], sync_lvl};
		end
		// stale sync history would fake a frame start on re-enable
		if (!cfg.port_en) begin
			nxt_smp = 2'b00;
		end
		if (!cfg.port_en || ext_sync) begin
			nxt_gen_cnt = 8'h00;
			nxt_sfs_out = cfg.sync_invert_bit;
		end else if (bclk_rise) begin
			nxt_gen_cnt = (gen_cnt_ff == clkc_ff[`CLKC_FRAME_MSB:`CLKC_FRAME_LSB]) ? 8'h00 : gen_cnt_ff + 8'h01;
			nxt_sfs_out = (nxt_gen_cnt < {3'b000, sync_len}) ^ cfg.sync_invert_bit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_ff <= 8'h00;
			int_sck_ff <= 1'b0;
			sck_prev_ff <= 1'b0;
			gen_cnt_ff <= 8'h00;
			sfs_out_ff <= 1'b0;
			smp_ff <= 2'b00;
		end else begin
			div_cnt_ff <= nxt_div_cnt;
			int_sck_ff <= nxt_int_sck;
			sck_prev_ff <= nxt_sck_prev;
			gen_cnt_ff <= nxt_gen_cnt;
			sfs_out_ff <= nxt_sfs_out;
			smp_ff <= nxt_smp;
		end
	end

	// word for the transmit shift register
	always_comb begin
		if (frz_ff) begin
			tx_word = tx_last_ff;
		end else if (dmac_ff[`DMAC_TX]) begin
			tx_word = tx_dma0_ff;
		end else if (tx_empty) begin
			tx_word = tx_mem_ff[tx_rptr_ff - 1'b1];
		end else begin
			tx_word = tx_mem_ff[tx_rptr_ff];
		end
		if (!wide) begin
			tx_word[15:8] = 8'h00;
		end
	end

	assign rx_in = cfg.loopback_bit ? tx_bit_ff : pin.rxd;
	assign rx_word = {rx_shift_reg_ff[14:0], rx_in};

	// serial link sequencer
	always_comb begin
		nxt_state = state_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_ctl_cnt = ctl_cnt_ff;
		nxt_phase = phase_ff;
		nxt_tx_shift_reg = tx_shift_reg_ff;
		nxt_rx_shift_reg = rx_shift_reg_ff;
		nxt_tx_bit = tx_bit_ff;
		tx_load = 1'b0;
		rx_done = 1'b0;
		if (shift_fall && state_ff == LINK_DATA) begin
			nxt_rx_shift_reg = rx_word;
			rx_done = (bit_cnt_ff == word_bits - 5'd1);
		end
		if (!cfg.port_en) begin
			nxt_state = LINK_IDLE;
		end else if (start) begin
			tx_load = 1'b1;
			nxt_state = LINK_DATA;
			nxt_bit_cnt = 5'd0;
			nxt_phase = 1'b1;
			nxt_tx_shift_reg = tx_word;
			nxt_tx_bit = wide ? tx_word[15] : tx_word[7];
		end else if (shift_rise) begin
			nxt_phase = 1'b1;
			unique case (state_ff)
				LINK_IDLE: begin
					nxt_state = LINK_IDLE;
				end
				LINK_DATA: begin
					if (bit_cnt_ff == word_bits - 5'd1) begin
						nxt_state = (ctrl_bit_count != 2'd0) ? LINK_CTRL : LINK_IDLE;
						nxt_ctl_cnt = 2'd0;
						nxt_tx_bit = ctrl_bits_value[0];
					end else begin
						nxt_bit_cnt = bit_cnt_ff + 5'd1;
						nxt_tx_shift_reg = {tx_shift_reg_ff[14:0], 1'b0};
						nxt_tx_bit = wide ? tx_shift_reg_ff[14] : tx_shift_reg_ff[6];
					end
				end
				LINK_CTRL: begin
					if (ctl_cnt_ff == ctrl_bit_count - 2'd1) begin
						nxt_state = LINK_IDLE;
					end else begin
						nxt_ctl_cnt = ctl_cnt_ff + 2'd1;
						nxt_tx_bit = ctrl_bits_value[nxt_ctl_cnt];
					end
				end
			endcase
		end else if (bclk_rise) begin
			nxt_phase = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= LINK_IDLE;
			bit_cnt_ff <= 5'd0;
			ctl_cnt_ff <= 2'd0;
			phase_ff <= 1'b0;
			tx_shift_reg_ff <= `ZERO16;
			rx_shift_reg_ff <= `ZERO16;
			tx_bit_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			bit_cnt_ff <= nxt_bit_cnt;
			ctl_cnt_ff <= nxt_ctl_cnt;
			phase_ff <= nxt_phase;
			tx_shift_reg_ff <= nxt_tx_shift_reg;
			rx_shift_reg_ff <= nxt_rx_shift_reg;
			tx_bit_ff <= nxt_tx_bit;
		end
	end

	// fifo levels and flags, derived from pointers and the last-write flags
	assign rx_diff = rx_wptr_ff - rx_read_ptr_ff;
	assign tx_diff = tx_wptr_ff - tx_rptr_ff;
	assign rx_full = (rx_diff == '0) & rx_lastw_ff;
	assign rx_empty = (rx_diff == '0) & ~rx_lastw_ff;
	assign tx_full = (tx_diff == '0) & tx_lastw_ff;
	assign tx_empty = (tx_diff == '0) & ~tx_lastw_ff;
	assign rx_cnt = rx_full ? DEPTH_C : {1'b0, rx_diff};
	assign tx_cnt = tx_full ? DEPTH_C : {1'b0, tx_diff};

	// apb decode; completion is the second access cycle
	assign idx = paddr[25:2];
	assign done = psel & penable & pready_ff;
	assign wr = done & pwrite & addr_ok;
	assign rd = done & ~pwrite & addr_ok;
	always_comb begin
		unique case (idx)
			`IDX_RX_FIFO_PORT, `IDX_RX_DMA_SLOT0, `IDX_RX_DMA_SLOT1, `IDX_RX_DMA_SLOT2,
			`IDX_RX_DMA_SLOT3, `IDX_TX_FIFO_PORT, `IDX_TX_DMA_SLOT0, `IDX_TX_DMA_SLOT1,
			`IDX_TX_DMA_SLOT2, `IDX_TX_DMA_SLOT3, `IDX_GLOBAL_CONFIG, `IDX_IRQ_STATUS_CTRL,
			`IDX_RX_STATUS_CTRL, `IDX_TX_STATUS_CTRL, `IDX_CLOCK_CTRL, `IDX_DMA_CTRL: begin
				addr_ok = (paddr[31:26] == 6'h00);
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	// register file, fifos and status
	always_comb begin
		nxt_gcfg = gcfg_ff;
		nxt_irqc = irqc_ff;
		nxt_clkc = clkc_ff;
		nxt_dmac = dmac_ff;
		nxt_txc = txc_ff;
		nxt_rx_dma0 = rx_dma0_ff;
		nxt_tx_dma0 = tx_dma0_ff;
		nxt_rx_ovr = rx_ovr_ff;
		nxt_tx_und = tx_und_ff;
		nxt_rx_mem = rx_mem_ff;
		nxt_tx_mem = tx_mem_ff;
		nxt_rx_wptr = rx_wptr_ff;
		nxt_rx_read_ptr = rx_read_ptr_ff;
		nxt_tx_wptr = tx_wptr_ff;
		nxt_tx_rptr = tx_rptr_ff;
		nxt_rx_lastw = rx_lastw_ff;
		nxt_tx_lastw = tx_lastw_ff;
		nxt_tx_last = tx_last_ff;
		nxt_pready = psel & penable & ~pready_ff;
		nxt_pslverr = psel & penable & ~pready_ff & ~addr_ok;
		nxt_prdata = 32'h0;
		// read data captured in the first access cycle
		if (psel && penable && !pready_ff && !pwrite) begin
			unique case (idx)
				`IDX_RX_FIFO_PORT: nxt_prdata[15:0] = rx_mem_ff[rx_read_ptr_ff];
				`IDX_RX_DMA_SLOT0: nxt_prdata[15:0] = rx_dma0_ff;
				`IDX_GLOBAL_CONFIG: nxt_prdata[15:0] = gcfg_ff;
				`IDX_IRQ_STATUS_CTRL: nxt_prdata[15:0] = irqc_ff;
				`IDX_RX_STATUS_CTRL: begin
					nxt_prdata[`STAT_STICKY] = rx_ovr_ff;
					nxt_prdata[`STAT_FULL] = rx_full;
					nxt_prdata[`STAT_EMPTY] = rx_empty;
					nxt_prdata[`STAT_LEVEL] = (rx_cnt >= RX_AF_C);
				end
				`IDX_TX_STATUS_CTRL: begin
					nxt_prdata[`TXC_CCNT_MSB:`TXC_CVAL_LSB] = txc_ff;
					nxt_prdata[`STAT_STICKY] = tx_und_ff;
					nxt_prdata[`STAT_FULL] = tx_full;
					nxt_prdata[`STAT_EMPTY] = tx_empty;
					nxt_prdata[`STAT_LEVEL] = (tx_cnt <= TX_AE_C);
				end
				`IDX_CLOCK_CTRL: nxt_prdata[15:0] = clkc_ff;
				`IDX_DMA_CTRL: nxt_prdata[15:0] = dmac_ff;
				default: nxt_prdata = 32'h0;
			endcase
		end
		// receive fifo pop on read
		// rx flags frozen
		if (rd && idx == `IDX_RX_FIFO_PORT && !frz_ff) begin
			nxt_rx_read_ptr = rx_read_ptr_ff + 1'b1;
			nxt_rx_lastw = 1'b0;
		end
		// received word to dma register or fifo
		// no rx update
		if (rx_done && !frz_ff) begin
			if (dmac_ff[`DMAC_RX]) begin
				nxt_rx_dma0 = rx_word;
			end else if (rx_full) begin
				nxt_rx_ovr = 1'b1;
			end else begin
				nxt_rx_mem[rx_wptr_ff] = rx_word;
				nxt_rx_wptr = rx_wptr_ff + 1'b1;
				nxt_rx_lastw = (rd && idx == `IDX_RX_FIFO_PORT) ? rx_lastw_ff : 1'b1;
			end
		end
		// transmit fifo push on write
		// tx flags frozen
		if (wr && idx == `IDX_TX_FIFO_PORT && !frz_ff) begin
			nxt_tx_mem[tx_wptr_ff] = pwdata[15:0];
			nxt_tx_wptr = tx_wptr_ff + 1'b1;
			nxt_tx_lastw = 1'b1;
		end
		// shift register reload; underrun repeats the previous word
		// no tx reload
		if (tx_load && !frz_ff) begin
			nxt_tx_last = tx_word;
			if (!dmac_ff[`DMAC_TX]) begin
				if (tx_empty) begin
					nxt_tx_und = 1'b1;
				end else begin
					nxt_tx_rptr = tx_rptr_ff + 1'b1;
					nxt_tx_lastw = (wr && idx == `IDX_TX_FIFO_PORT) ? tx_lastw_ff : 1'b0;
				end
			end
		end
		// plain register writes; sticky clears lose to a same-cycle set
		if (wr) begin
			unique case (idx)
				`IDX_TX_DMA_SLOT0: nxt_tx_dma0 = pwdata[15:0];
				`IDX_GLOBAL_CONFIG: begin
					nxt_gcfg = pwdata[15:0];
					nxt_gcfg[`STAT_STICKY] = 1'b0;
					nxt_gcfg[`STAT_FULL] = 1'b0;
					if (pwdata[`STAT_STICKY]) begin
						nxt_rx_wptr = '0;
						nxt_rx_read_ptr = '0;
						nxt_rx_lastw = 1'b0;
					end
					if (pwdata[`STAT_FULL]) begin
						nxt_tx_wptr = '0;
						nxt_tx_rptr = '0;
						nxt_tx_lastw = 1'b0;
					end
				end
				`IDX_IRQ_STATUS_CTRL: nxt_irqc = pwdata[15:0];
				`IDX_RX_STATUS_CTRL: begin
					if (pwdata[`STAT_STICKY] && !frz_ff && !(rx_done && rx_full && !dmac_ff[`DMAC_RX])) begin
						nxt_rx_ovr = 1'b0;
					end
				end
				`IDX_TX_STATUS_CTRL: begin
					nxt_txc = pwdata[`TXC_CCNT_MSB:`TXC_CVAL_LSB];
					if (pwdata[`STAT_STICKY] && !frz_ff && !(tx_load && tx_empty && !dmac_ff[`DMAC_TX])) begin
						nxt_tx_und = 1'b0;
					end
				end
				`IDX_CLOCK_CTRL: nxt_clkc = pwdata[15:0];
				`IDX_DMA_CTRL: nxt_dmac = pwdata[15:0];
				default: nxt_dmac = dmac_ff;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gcfg_ff <= `CFG_RESET;
			irqc_ff <= `ZERO16;
			clkc_ff <= `CLKC_RESET;
			dmac_ff <= `ZERO16;
			txc_ff <= 5'h00;
			rx_dma0_ff <= `ZERO16;
			tx_dma0_ff <= `ZERO16;
			rx_ovr_ff <= 1'b0;
			tx_und_ff <= 1'b0;
			rx_mem_ff <= '{default: `ZERO16};
			tx_mem_ff <= '{default: `ZERO16};
			rx_wptr_ff <= '0;
			rx_read_ptr_ff <= '0;
			tx_wptr_ff <= '0;
			tx_rptr_ff <= '0;
			rx_lastw_ff <= 1'b0;
			tx_lastw_ff <= 1'b0;
			tx_last_ff <= `ZERO16;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0;
		end else begin
			gcfg_ff <= nxt_gcfg;
			irqc_ff <= nxt_irqc;
			clkc_ff <= nxt_clkc;
			dmac_ff <= nxt_dmac;
			txc_ff <= nxt_txc;
			rx_dma0_ff <= nxt_rx_dma0;
			tx_dma0_ff <= nxt_tx_dma0;
			rx_ovr_ff <= nxt_rx_ovr;
			tx_und_ff <= nxt_tx_und;
			rx_mem_ff <= nxt_rx_mem;
			tx_mem_ff <= nxt_tx_mem;
			rx_wptr_ff <= nxt_rx_wptr;
			rx_read_ptr_ff <= nxt_rx_read_ptr;
			tx_wptr_ff <= nxt_tx_wptr;
			tx_rptr_ff <= nxt_tx_rptr;
			rx_lastw_ff <= nxt_rx_lastw;
			tx_lastw_ff <= nxt_tx_lastw;
			tx_last_ff <= nxt_tx_last;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			prdata_ff <= nxt_prdata;
		end
	end

	// outputs; enables are low while driving
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign sck_out = int_sck_ff;
	assign sck_oe_n = ext_clk | ~cfg.clk_en;
	assign sfs_out = sfs_out_ff;
	assign sfs_oe_n = ext_sync | ~cfg.port_en;
	assign serial_tx_pin = tx_bit_ff;
	assign serial_tx_oe_n = (state_ff == LINK_IDLE);

endmodule // audio_port

/* audio_port_properties.sv */
`timescale 1ns/1ps
module audio_port_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sck_out,
	input wire logic sck_oe_n,
	input wire logic sfs_oe_n,
	input wire logic serial_tx_pin,
	input wire logic serial_tx_oe_n
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// bus handshake timing
	a_apb_wait_state: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
		else $error("ready not in second access cycle");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("ready outside access phase");
	a_ready_after_access: assert property (pready |-> $past(psel) && $past(penable))
		else $error("ready without prior access cycle");
	a_slverr_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_upper_half_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	// outputs idle at the first edge after reset
	a_release_idle: assert property ($rose(presetn) |-> sck_oe_n && sfs_oe_n && serial_tx_oe_n && !pready)
		else $error("outputs not idle after reset");
	// transmit data moves only with the bit clock
	a_tx_on_clock: assert property (!sck_oe_n && !serial_tx_oe_n && $stable(serial_tx_oe_n) && $changed(serial_tx_pin)
		|-> $changed(sck_out) || $past(sck_out) != $past(sck_out, 2))
		else $error("transmit bit changed away from clock edge");
	c_read: cover property (pready && !pwrite);
	c_error: cover property (pready && pslverr);
	c_tx_active: cover property (!serial_tx_oe_n && !sck_oe_n);
endmodule // audio_port_properties

bind audio_port audio_port_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
	.sfs_oe_n(sfs_oe_n), .serial_tx_pin(serial_tx_pin), .serial_tx_oe_n(serial_tx_oe_n));

/* codec_model.sv */
`timescale 1ns/1ps
module codec_model (
	output logic sck,
	output logic sfs,
	output logic rx_line,
	input wire logic tx_line
);
	logic [18:0] cap;
	initial begin
		sck = 0;
		sfs = 0;
		rx_line = 0;
		cap = 0;
	end
	// one frame of 24 bits, sp bit clocks per bit, 320 ns bit clock, clock stands low outside
	task automatic frame(input logic [15:0] d, input int sp);
		int j;
		#13;
		for (int k = 0; k < 24 * sp; k++) begin
			j = k / sp;
			sck = 1;
			sfs = k >= 3 * sp - 1 && k < 6 * sp - 1;
			rx_line = j >= 3 && j < 19 ? d[18-j] : ~rx_line;
			#160;
			sck = 0;
			#150;
			if (j >= 3 && j < 22 && k % sp == sp - 1) begin
				cap = {cap[17:0], tx_line};
			end
			#10;
		end
	endtask
endmodule // codec_model

/* tb_top.sv */
`timescale 1ns/1ps
`include "audio_port_regs.svh"
module tb_top;
	import audio_port_pkg::*;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic freeze = 0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, sck_out, sck_oe_n, sfs_out, sfs_oe_n, tx_line, se, sck_w, sfs_w;
	logic sck, sfs, rx_line;
	logic [31:0] seed = 32'h000005ff;
	logic [31:0] expq[$];
	logic [15:0] cf[7] = '{16'hc002, 16'hc040, 16'hc042, 16'hc442, 16'hc842, 16'hcc42, 16'hd442};
	int ln[7] = '{1, 6, 13, 14, 15, 16, 14};
	int error_cnt = 0;
	int checks = 0;
	always #20 pclk = ~pclk;
	// shared pins: design drives when enable is low
	assign sck_w = sck_oe_n ? sck : sck_out;
	assign sfs_w = sfs_oe_n ? sfs : sfs_out;
	audio_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_in(sck_w), .sck_out(sck_out),
		.sck_oe_n(sck_oe_n), .sfs_in(sfs_w), .sfs_out(sfs_out), .sfs_oe_n(sfs_oe_n), .serial_rx_pin(rx_line),
		.serial_tx_pin(tx_line), .serial_tx_oe_n(), .freeze(freeze));
	codec_model codec (.sck(sck), .sfs(sfs), .rx_line(rx_line), .tx_line(tx_line));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask
	// one bus transfer after an idle edge, waits for ready; the watchdog ends a hang
	task automatic apb(input logic w, input logic [23:0] idx, input logic [15:0] d, output logic [31:0] r);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= {6'h00, idx, 2'b00};
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wait_lvl(input logic v);
		int n;
		n = 0;
		while (sfs_out !== v && n < 2000) begin
			@(posedge pclk);
			n++;
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		#2ms;
		error_cnt++;
		end_of_test();
	end
	initial begin
		logic [31:0] r;
		logic [31:0] mk;
		logic [15:0] w, s0, t0;
		logic a;
		int n;
		repeat (10) @(posedge pclk);
		presetn <= 1;
		// reset values and an unmapped address
		apb(0, `IDX_GLOBAL_CONFIG, 16'h0000, r);
		chk("cfg_reset", 32'h0, r);
		apb(0, `IDX_CLOCK_CTRL, 16'h0000, r);
		chk("clk_reset", 32'h1f03, r);
		apb(0, 24'hfffd60, 16'h0000, r);
		chk("unmapped", 32'h1, se);
		// generated sync widths at four pclk per bit
		apb(1, `IDX_CLOCK_CTRL, 16'h1f01, r);
		for (int i = 0; i < 7; i++) begin
			apb(1, `IDX_GLOBAL_CONFIG, cf[i], r);
			a = ~cf[i][12];
			repeat (2) begin
				wait_lvl(~a);
				wait_lvl(a);
			end
			n = 0;
			while (sfs_out === a && n < 200) begin
				@(posedge pclk);
				n++;
			end
			chk("sync_len", ln[i] * 4, n);
		end
		// loopback, 16 then 8 bit words
		for (int m = 0; m < 2; m++) begin
			r = rnd();
			w = r[15:0];
			mk = m ? 32'h00ff : 32'hffff;
			expq.push_back(w & mk);
			apb(1, `IDX_GLOBAL_CONFIG, 16'h0300, r);
			apb(1, `IDX_TX_FIFO_PORT, w, r);
			apb(1, `IDX_GLOBAL_CONFIG, m ? 16'hc004 : 16'hc006, r);
			repeat (600) @(posedge pclk);
			apb(0, `IDX_RX_FIFO_PORT, 16'h0000, r);
			chk("loop_word", expq.pop_front(), r & mk);
		end
		// freeze holds flags while frames keep coming
		freeze <= 1;
		repeat (10) @(posedge pclk);
		apb(0, `IDX_RX_STATUS_CTRL, 16'h0000, r);
		s0 = r[15:0];
		apb(0, `IDX_TX_STATUS_CTRL, 16'h0000, r);
		t0 = r[15:0];
		chk("tx_flags_pre", 32'h0d00, t0 & 16'h0f00);
		apb(0, `IDX_RX_FIFO_PORT, 16'h0000, r);
		apb(1, `IDX_TX_FIFO_PORT, w, r);
		repeat (1700) @(posedge pclk);
		apb(0, `IDX_RX_STATUS_CTRL, 16'h0000, r);
		chk("rx_flags", s0 & 16'h0f00, r & 32'h0f00);
		apb(0, `IDX_TX_STATUS_CTRL, 16'h0000, r);
		chk("tx_flags", t0 & 16'h0f00, r & 32'h0f00);
		freeze <= 0;
		// external clock and long sync, then isdn slave with two bit clocks per bit, three control bits
		for (int e = 0; e < 2; e++) begin
			apb(1, `IDX_GLOBAL_CONFIG, 16'h0300, r);
			apb(1, `IDX_CLOCK_CTRL, e ? 16'h00be : 16'h1f01, r);
			apb(1, `IDX_TX_STATUS_CTRL, 16'h001b, r);
			r = rnd();
			w = r[15:0];
			apb(1, `IDX_TX_FIFO_PORT, w, r);
			apb(1, `IDX_GLOBAL_CONFIG, e ? 16'h60e2 : 16'h40e2, r);
			repeat (2) begin
				r = rnd();
				expq.push_back({16'h0000, r[15:0]});
				codec.frame(r[15:0], e + 1);
				chk("tx_frame", {w, 3'b110}, codec.cap);
			end
			repeat (2) begin
				apb(0, `IDX_RX_FIFO_PORT, 16'h0000, r);
				chk("rx_word", expq.pop_front(), r);
			end
		end
		end_of_test();
	end
endmodule // tb_top
